// ---- hw/dsea_top.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - Decode lowest 2144 addresses: 96 registers, 2048 SRAM
// - Registers at 0x00-0x1F, I/O at 0x20-0x5F
// - SRAM contiguous at 0x0060 through 0x085F
// - SRAM access completes in two clocks
// - Separate 1024-byte nonvolatile store, byte accesses
// - Ten-bit linear nonvolatile address, 0 to 1023
// - Address bits 15..10 read zero, not writable
// - Address undefined at reset; software sets it first
// - Write stores data byte at selected address
// - Read loads data byte from selected address
// - Read stalls CPU four cycles
// - Write start stalls CPU two cycles
// - Write self-timed; strobe bit shows completion
// - Write only accepted via arming sequence
// - Access registers sit in I/O window
// - Arm clears after four cycles; gates strobe
// - Write strobe stays set for programming time
// - Read data available within triggering instruction
// - During write: reads ignored, address frozen
module dsea_top #(
    parameter int unsigned PROG_CLKS = dsea_pkg::NV_PROG_CLKS
) (
    input  wire logic        CLK,
    input  wire logic        RST_B,
    input  wire logic [15:0] DS_ADDR,
    input  wire logic        DS_RD,
    input  wire logic        DS_WR,
    input  wire logic [7:0]  DS_WDATA,
    output logic      [7:0]  DS_RDATA,
    output logic             DS_DONE,
    output logic             RF_SEL,
    output logic             IO_SEL,
    output logic      [5:0]  IO_NUM,
    output logic             SRAM_SEL,
    output logic             CPU_HALT
);
    if (PROG_CLKS < 2) begin : g_chk
        $error("dsea_top: PROG_CLKS too small");
    end

    dsea_nv_if nv ();

    logic                         rf_hit;
    logic                         io_hit;
    logic                         sram_hit;
    logic                         nv_hit;
    logic                         req;
    logic                         take;
    logic [5:0]                   io_num;
    logic                         wr_lo;
    logic                         wr_hi;
    logic                         wr_data;
    logic                         wr_ctrl;
    logic                         rd_go;
    logic                         wr_go;
    logic                         arm_set;
    logic                         arm_q;
    logic                         wr_flag;
    logic                         rd_flag;
    logic [7:0]                   io_rdata;

    logic [dsea_pkg::NV_AW-1:0]   addr_q;
    logic [7:0]                   data_q;
    logic [2:0]                   arm_cnt_q;
    logic [2:0]                   halt_cnt_q;
    logic                         wr_start_q;
    logic                         rd_pend_q;
    logic                         ld_q;

    dsea_pkg::dsea_sram_st_t      sram_st_q;
    logic [7:0]                   sram [dsea_pkg::SRAM_DEPTH];
    logic [dsea_pkg::SRAM_AW-1:0] sram_idx_q;
    logic                         sram_we_q;
    logic [7:0]                   sram_wd_q;
    logic [7:0]                   rdata_q;
    logic                         done_q;

    // Address decode
    assign rf_hit   = (DS_ADDR <= dsea_pkg::RF_LAST);
    assign io_hit   = (DS_ADDR >= dsea_pkg::IO_BASE) && (DS_ADDR <= dsea_pkg::IO_LAST);
    assign sram_hit = (DS_ADDR >= dsea_pkg::SRAM_BASE) && (DS_ADDR <= dsea_pkg::SRAM_LAST);
    assign io_num   = 6'(DS_ADDR - dsea_pkg::IO_BASE);
    assign nv_hit   = io_hit && (io_num >= dsea_pkg::IO_NV_CTRL) && (io_num <= dsea_pkg::IO_NV_ADDR_HI);

    assign RF_SEL   = rf_hit;
    assign IO_SEL   = io_hit && !nv_hit;
    assign IO_NUM   = io_num;
    assign SRAM_SEL = sram_hit;

    // Requests are ignored while an SRAM access is still in flight
    assign req  = DS_RD || DS_WR;
    assign take = req && (sram_st_q == dsea_pkg::SRAM_IDLE);

    assign wr_lo   = take && DS_WR && nv_hit && (io_num == dsea_pkg::IO_NV_ADDR_LO);
    assign wr_hi   = take && DS_WR && nv_hit && (io_num == dsea_pkg::IO_NV_ADDR_HI);
    assign wr_data = take && DS_WR && nv_hit && (io_num == dsea_pkg::IO_NV_DATA);
    assign wr_ctrl = take && DS_WR && nv_hit && (io_num == dsea_pkg::IO_NV_CTRL);

    // Strobe status covers the start cycle before the store reports busy
    assign wr_flag = wr_start_q || nv.busy;
    assign rd_flag = rd_pend_q || ld_q;
    assign arm_q   = (arm_cnt_q != 3'h0);

    assign arm_set = wr_ctrl && DS_WDATA[dsea_pkg::CTRL_ARM_BIT];
    // Strobe uses the arm state from before this write, so both bits at once only arm unless already armed
    assign wr_go   = wr_ctrl && DS_WDATA[dsea_pkg::CTRL_WR_BIT] && arm_q && !wr_flag;
    assign rd_go   = wr_ctrl && DS_WDATA[dsea_pkg::CTRL_RD_BIT] && !wr_flag;

    assign nv.addr     = addr_q;
    assign nv.wdata    = data_q;
    assign nv.rd_en    = rd_pend_q;
    assign nv.wr_start = wr_start_q;

    assign CPU_HALT = (halt_cnt_q != 3'h0);
    assign DS_RDATA = rdata_q;
    assign DS_DONE  = done_q;

    dsea_nv_store #(
        .PROG_CLKS (PROG_CLKS),
        .DEPTH     (dsea_pkg::NV_DEPTH)
    ) u_store (
        .clk   (CLK),
        .rst_b (RST_B),
        .nv    (nv)
    );

    // Address field has no reset value; software must load it
    always_ff @(posedge CLK) begin
        if (wr_lo && !wr_flag) begin
            addr_q[7:0] <= DS_WDATA;
        end
        if (wr_hi && !wr_flag) begin
            addr_q[dsea_pkg::NV_AW-1:8] <= DS_WDATA[dsea_pkg::NV_AW-9:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            data_q <= dsea_pkg::DATA_RST;
        end else if (ld_q) begin
            data_q <= nv.rdata;
        end else if (wr_data) begin
            data_q <= DS_WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            arm_cnt_q <= 3'h0;
        end else if (arm_set) begin
            arm_cnt_q <= dsea_pkg::ARM_CLKS;
        end else if (arm_q) begin
            arm_cnt_q <= arm_cnt_q - 3'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            wr_start_q <= 1'b0;
            rd_pend_q  <= 1'b0;
            ld_q       <= 1'b0;
        end else begin
            wr_start_q <= wr_go;
            rd_pend_q  <= rd_go;
            ld_q       <= rd_pend_q;
        end
    end

    // Read wins the longer stall if both strobes arrive together
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            halt_cnt_q <= 3'h0;
        end else if (rd_go) begin
            halt_cnt_q <= dsea_pkg::RD_HALT;
        end else if (wr_go) begin
            halt_cnt_q <= dsea_pkg::WR_HALT;
        end else if (CPU_HALT) begin
            halt_cnt_q <= halt_cnt_q - 3'h1;
        end
    end

    always_comb begin
        case (io_num)
            dsea_pkg::IO_NV_CTRL:    io_rdata = {5'h00, arm_q, wr_flag, rd_flag};
            dsea_pkg::IO_NV_DATA:    io_rdata = data_q;
            dsea_pkg::IO_NV_ADDR_LO: io_rdata = addr_q[7:0];
            dsea_pkg::IO_NV_ADDR_HI: io_rdata = {6'h00, addr_q[dsea_pkg::NV_AW-1:8]};
            default:                 io_rdata = 8'h00;
        endcase
    end

    // SRAM: request cycle, then access cycle
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sram_st_q <= dsea_pkg::SRAM_IDLE;
        end else begin
            case (sram_st_q)
                dsea_pkg::SRAM_IDLE: begin
                    if (take && sram_hit) begin
                        sram_st_q <= dsea_pkg::SRAM_ACCESS;
                    end
                end
                dsea_pkg::SRAM_ACCESS: sram_st_q <= dsea_pkg::SRAM_IDLE;
                default:               sram_st_q <= dsea_pkg::SRAM_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (take && sram_hit) begin
            sram_idx_q <= dsea_pkg::SRAM_AW'(DS_ADDR - dsea_pkg::SRAM_BASE);
            sram_we_q  <= DS_WR;
            sram_wd_q  <= DS_WDATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (sram_st_q == dsea_pkg::SRAM_ACCESS && sram_we_q) begin
            sram[sram_idx_q] <= sram_wd_q;
        end
    end

    // Register file and foreign I/O answer elsewhere; unmapped space reads zero
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rdata_q <= 8'h00;
            done_q  <= 1'b0;
        end else if (sram_st_q == dsea_pkg::SRAM_ACCESS) begin
            rdata_q <= sram_we_q ? 8'h00 : sram[sram_idx_q];
            done_q  <= 1'b1;
        end else if (take && (nv_hit || (!rf_hit && !io_hit && !sram_hit))) begin
            rdata_q <= (DS_RD && nv_hit) ? io_rdata : 8'h00;
            done_q  <= 1'b1;
        end else begin
            done_q  <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_halt4;
        CPU_HALT [*4] ##1 !CPU_HALT;
    endsequence

    sequence s_halt2;
        CPU_HALT [*2] ##1 !CPU_HALT;
    endsequence

    sequence s_arm_quiet;
        ##1 (!arm_set) [*4];
    endsequence

    property p_sram_two;
        (take && sram_hit) |=> !DS_DONE ##1 DS_DONE;
    endproperty
    a_sram_two: assert property (p_sram_two) else $error("SRAM answer not at second cycle");

    property p_decode;
        (DS_ADDR > dsea_pkg::SRAM_LAST) |-> !RF_SEL && !IO_SEL && !SRAM_SEL;
    endproperty
    a_decode: assert property (p_decode) else $error("address above window selected");

    property p_io_window;
        (DS_ADDR == dsea_pkg::IO_BASE) |-> !RF_SEL && IO_SEL && IO_NUM == 6'h00;
    endproperty
    a_io_window: assert property (p_io_window) else $error("I/O window base misdecoded");

    property p_rd_halt;
        (rd_go && !wr_go) |=> s_halt4;
    endproperty
    a_rd_halt: assert property (p_rd_halt) else $error("read stall not four cycles");

    property p_wr_halt;
        (wr_go && !rd_go) |=> s_halt2;
    endproperty
    a_wr_halt: assert property (p_wr_halt) else $error("write stall not two cycles");

    property p_arm_timeout;
        (arm_set ##0 s_arm_quiet) |=> !arm_q;
    endproperty
    a_arm_timeout: assert property (p_arm_timeout) else $error("arm bit not cleared after four");

    property p_no_arm_no_write;
        (wr_ctrl && !arm_q && !wr_flag) |=> !wr_start_q;
    endproperty
    a_no_arm_no_write: assert property (p_no_arm_no_write) else $error("write started unarmed");

    property p_addr_frozen;
        wr_flag |=> (addr_q == $past(addr_q));
    endproperty
    a_addr_frozen: assert property (p_addr_frozen) else $error("address changed during write");

    property p_rd_pulse;
        rd_go |=> rd_pend_q ##1 (!rd_pend_q && ld_q) ##1 !ld_q;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe not a single pulse");

    property p_hi_zero;
        (take && DS_RD && nv_hit && io_num == dsea_pkg::IO_NV_ADDR_HI) |=> DS_DONE && DS_RDATA[7:2] == 6'h00;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper address bits not zero");

    sequence s_wr_handover;
        wr_start_q ##1 nv.busy;
    endsequence

    property p_wr_flag_cont;
        wr_go |=> s_wr_handover;
    endproperty
    a_wr_flag_cont: assert property (p_wr_flag_cont) else $error("write flag gap at store handover");

    property p_ld_data;
        ld_q |=> (data_q == $past(nv.rdata));
    endproperty
    a_ld_data: assert property (p_ld_data) else $error("read byte not loaded");

    property p_addr_lo_load;
        (wr_lo && !wr_flag) |=> (addr_q[7:0] == $past(DS_WDATA));
    endproperty
    a_addr_lo_load: assert property (p_addr_lo_load) else $error("address low byte not loaded");

    property p_addr_hi_load;
        (wr_hi && !wr_flag) |=> (addr_q[dsea_pkg::NV_AW-1:8] == $past(DS_WDATA[dsea_pkg::NV_AW-9:0]));
    endproperty
    a_addr_hi_load: assert property (p_addr_hi_load) else $error("address high bits not loaded");

    property p_rd_refused;
        (wr_ctrl && DS_WDATA[dsea_pkg::CTRL_RD_BIT] && wr_flag) |=> !rd_pend_q;
    endproperty
    a_rd_refused: assert property (p_rd_refused) else $error("read accepted during write");

    property p_ctrl_read;
        (take && DS_RD && nv_hit && io_num == dsea_pkg::IO_NV_CTRL) |=> DS_DONE && DS_RDATA[7:3] == 5'h00;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control register answer wrong");

    property p_sram_base;
        (DS_ADDR == dsea_pkg::SRAM_BASE) |-> SRAM_SEL && !IO_SEL && !RF_SEL;
    endproperty
    a_sram_base: assert property (p_sram_base) else $error("SRAM base misdecoded");

    property p_sram_index;
        (take && sram_hit && DS_ADDR == dsea_pkg::SRAM_BASE) |=> (sram_idx_q == '0);
    endproperty
    a_sram_index: assert property (p_sram_index) else $error("SRAM base not at index zero");

    property p_nv_window;
        nv_hit |-> io_hit && !IO_SEL && !RF_SEL;
    endproperty
    a_nv_window: assert property (p_nv_window) else $error("access registers outside I/O window");

endmodule : dsea_top

// ---- hw/dsea_pkg.sv ----
package dsea_pkg;

    // Data-space windows
    localparam logic [15:0] RF_BASE   = 16'h0000;
    localparam logic [15:0] RF_LAST   = 16'h001F;
    localparam logic [15:0] IO_BASE   = 16'h0020;
    localparam logic [15:0] IO_LAST   = 16'h005F;
    localparam logic [15:0] SRAM_BASE = 16'h0060;
    localparam logic [15:0] SRAM_LAST = 16'h085F;

    localparam int unsigned SRAM_DEPTH = 2048;
    localparam int unsigned SRAM_AW    = 11;
    localparam int unsigned NV_DEPTH   = 1024;
    localparam int unsigned NV_AW      = 10;

    // I/O numbers of the nonvolatile access registers
    localparam logic [5:0] IO_NV_CTRL    = 6'h1C;
    localparam logic [5:0] IO_NV_DATA    = 6'h1D;
    localparam logic [5:0] IO_NV_ADDR_LO = 6'h1E;
    localparam logic [5:0] IO_NV_ADDR_HI = 6'h1F;

    // Control register fields
    localparam int unsigned CTRL_RD_BIT  = 0;
    localparam int unsigned CTRL_WR_BIT  = 1;
    localparam int unsigned CTRL_ARM_BIT = 2;

    localparam logic [7:0] DATA_RST = 8'h00;

    // Timing
    localparam logic [2:0] ARM_CLKS = 3'h4;
    localparam logic [2:0] RD_HALT  = 3'h4;
    localparam logic [2:0] WR_HALT  = 3'h2;

    localparam int unsigned PROG_OSC_CYCLES = 8448;
    localparam int unsigned OSC_HZ          = 1000000;
    localparam int unsigned CLK_HZ          = 125000000;
    localparam int unsigned NV_PROG_CLKS    = PROG_OSC_CYCLES * (CLK_HZ / OSC_HZ);

    typedef enum logic {SRAM_IDLE, SRAM_ACCESS} dsea_sram_st_t;
    typedef enum logic {NV_IDLE, NV_PROG} dsea_nv_st_t;

endpackage : dsea_pkg

// ---- hw/dsea_nv_if.sv ----
`timescale 1ns/10ps
interface dsea_nv_if;
    logic [dsea_pkg::NV_AW-1:0] addr;
    logic [7:0]                 wdata;
    logic                       rd_en;
    logic                       wr_start;
    logic [7:0]                 rdata;
    logic                       busy;

    modport ctrl  (output addr, output wdata, output rd_en, output wr_start, input rdata, input busy);
    modport store (input addr, input wdata, input rd_en, input wr_start, output rdata, output busy);
endinterface : dsea_nv_if

// ---- hw/dsea_nv_store.sv ----
`timescale 1ns/10ps
module dsea_nv_store #(
    parameter int unsigned PROG_CLKS = dsea_pkg::NV_PROG_CLKS,
    parameter int unsigned DEPTH     = dsea_pkg::NV_DEPTH
) (
    input wire logic   clk,
    input wire logic   rst_b,
    dsea_nv_if.store   nv
);
    localparam int unsigned CW = $clog2(PROG_CLKS + 1);

    if (PROG_CLKS < 2 || DEPTH != (1 << dsea_pkg::NV_AW)) begin : g_chk
        $error("dsea_nv_store: unsupported parameters");
    end

    // Nonvolatile contents: never cleared by reset
    logic [7:0]                 mem [DEPTH];
    dsea_pkg::dsea_nv_st_t      st_q;
    logic [CW-1:0]              cnt_q;
    logic [dsea_pkg::NV_AW-1:0] wa_q;
    logic [7:0]                 wd_q;
    logic [7:0]                 rdata_q;
    logic                       last;

    assign last     = (cnt_q == CW'(PROG_CLKS - 1));
    assign nv.busy  = (st_q == dsea_pkg::NV_PROG);
    assign nv.rdata = rdata_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q  <= dsea_pkg::NV_IDLE;
            cnt_q <= '0;
        end else begin
            case (st_q)
                dsea_pkg::NV_IDLE: begin
                    cnt_q <= '0;
                    if (nv.wr_start) begin
                        st_q <= dsea_pkg::NV_PROG;
                    end
                end
                dsea_pkg::NV_PROG: begin
                    if (last) begin
                        st_q <= dsea_pkg::NV_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: st_q <= dsea_pkg::NV_IDLE;
            endcase
        end
    end

    // Byte and address frozen for the whole programming time
    always_ff @(posedge clk) begin
        if (st_q == dsea_pkg::NV_IDLE && nv.wr_start) begin
            wa_q <= nv.addr;
            wd_q <= nv.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (st_q == dsea_pkg::NV_PROG && last) begin
            mem[wa_q] <= wd_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else if (nv.rd_en && st_q == dsea_pkg::NV_IDLE) begin
            rdata_q <= mem[nv.addr];
        end
    end

    property p_prog_hold;
        @(posedge clk) disable iff (!rst_b)
        (nv.busy && !last) |=> nv.busy;
    endproperty
    a_prog_hold: assert property (p_prog_hold) else $error("write ended early");

    property p_prog_end;
        @(posedge clk) disable iff (!rst_b)
        (nv.busy && last) |=> !nv.busy;
    endproperty
    a_prog_end: assert property (p_prog_end) else $error("write did not end on time");

endmodule : dsea_nv_store

// ---- verif/dsea_cpu_model.sv ----
`timescale 1ns/10ps
module dsea_cpu_model (
    input  wire logic        CLK,
    output logic      [15:0] DS_ADDR,
    output logic             DS_RD,
    output logic             DS_WR,
    output logic      [7:0]  DS_WDATA,
    input  wire logic [7:0]  DS_RDATA,
    input  wire logic        DS_DONE,
    input  wire logic        CPU_HALT
);
    logic [7:0] rdata;
    logic       got_done;
    int         lat;
    int         halt_n;

    initial begin
        DS_ADDR  = 16'h0000;
        DS_RD    = 1'b0;
        DS_WR    = 1'b0;
        DS_WDATA = 8'h00;
        rdata    = 8'h00;
        got_done = 1'b0;
        lat      = 0;
        halt_n   = 0;
    end

    // Address only, for the combinational decode
    task automatic peek(input logic [15:0] addr);
        @(posedge CLK);
        #1;
        DS_ADDR = addr;
        @(negedge CLK);
    endtask : peek

    // One-cycle request, bounded wait for the answer, then sit out the stall
    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] data);
        @(posedge CLK);
        #1;
        DS_ADDR  = addr;
        DS_WDATA = data;
        DS_WR    = wr;
        DS_RD    = ~wr;
        @(posedge CLK);
        #1;
        DS_WR    = 1'b0;
        DS_RD    = 1'b0;
        // Released lines flip so stale values cannot pass for valid
        DS_ADDR  = ~addr;
        DS_WDATA = ~data;
        got_done = 1'b0;
        lat      = 1;
        halt_n   = 0;
        @(negedge CLK);
        while (DS_DONE !== 1'b1 && lat < 8) begin
            lat++;
            @(negedge CLK);
        end
        got_done = (DS_DONE === 1'b1);
        rdata    = DS_RDATA;
        // No new request while stalled
        while (CPU_HALT === 1'b1 && halt_n < 16) begin
            halt_n++;
            @(negedge CLK);
        end
    endtask : access
endmodule : dsea_cpu_model

// ---- verif/dsea_top_tb.sv ----
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
        end \
    end
module dsea_top_tb;
    localparam int unsigned PROG = 20;
    localparam logic [15:0] A_CTRL = dsea_pkg::IO_BASE + {10'h000, dsea_pkg::IO_NV_CTRL};
    localparam logic [15:0] A_DATA = dsea_pkg::IO_BASE + {10'h000, dsea_pkg::IO_NV_DATA};
    localparam logic [15:0] A_ADLO = dsea_pkg::IO_BASE + {10'h000, dsea_pkg::IO_NV_ADDR_LO};
    localparam logic [15:0] A_ADHI = dsea_pkg::IO_BASE + {10'h000, dsea_pkg::IO_NV_ADDR_HI};

    logic        CLK;
    logic        RST_B;
    logic [15:0] DS_ADDR;
    logic        DS_RD;
    logic        DS_WR;
    logic [7:0]  DS_WDATA;
    logic [7:0]  DS_RDATA;
    logic        DS_DONE;
    logic        RF_SEL;
    logic        IO_SEL;
    logic [5:0]  IO_NUM;
    logic        SRAM_SEL;
    logic        CPU_HALT;
    int          failures;
    int          total_checks;
    logic [15:0] probe [11];

    dsea_top #(.PROG_CLKS(PROG)) DUT (
        .CLK      (CLK),
        .RST_B    (RST_B),
        .DS_ADDR  (DS_ADDR),
        .DS_RD    (DS_RD),
        .DS_WR    (DS_WR),
        .DS_WDATA (DS_WDATA),
        .DS_RDATA (DS_RDATA),
        .DS_DONE  (DS_DONE),
        .RF_SEL   (RF_SEL),
        .IO_SEL   (IO_SEL),
        .IO_NUM   (IO_NUM),
        .SRAM_SEL (SRAM_SEL),
        .CPU_HALT (CPU_HALT)
    );

    dsea_cpu_model cpu (
        .CLK      (CLK),
        .DS_ADDR  (DS_ADDR),
        .DS_RD    (DS_RD),
        .DS_WR    (DS_WR),
        .DS_WDATA (DS_WDATA),
        .DS_RDATA (DS_RDATA),
        .DS_DONE  (DS_DONE),
        .CPU_HALT (CPU_HALT)
    );

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    task automatic wrap_up();
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cpu.access(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        cpu.access(1'b0, a, 8'h00);
        `CHK(cpu.rdata, exp)
    endtask : rd_chk

    // Address low, address high, then data; address always set first
    task automatic nv_load(input logic [9:0] a, input logic [7:0] d);
        wr(A_ADLO, a[7:0]);
        wr(A_ADHI, {6'h00, a[9:8]});
        wr(A_DATA, d);
    endtask : nv_load

    // Polling is cheaper than a fixed wait and tracks the real busy time
    task automatic wait_idle(output int polls);
        polls = 0;
        do begin
            cpu.access(1'b0, A_CTRL, 8'h00);
            polls++;
        end while (cpu.rdata[1] === 1'b1 && polls < 100);
    endtask : wait_idle

    task automatic nv_write(input logic [9:0] a, input logic [7:0] d);
        int polls;
        nv_load(a, d);
        wr(A_CTRL, 8'h04);
        wr(A_CTRL, 8'h02);
        `CHK(cpu.halt_n, 2)
        wait_idle(polls);
        `CHK(polls < 100, 1'b1)
    endtask : nv_write

    task automatic nv_read(input logic [9:0] a, input logic [7:0] exp);
        wr(A_ADLO, a[7:0]);
        wr(A_ADHI, {6'h00, a[9:8]});
        wr(A_CTRL, 8'h01);
        `CHK(cpu.halt_n, 4)
        rd_chk(A_DATA, exp);
    endtask : nv_read

    initial begin
        #100000;
        failures++;
        wrap_up();
    end

    initial begin
        logic [15:0] a;
        logic        nv;
        int          polls;
        failures     = 0;
        total_checks = 0;
        probe = '{16'h0000, 16'h001F, 16'h0020, 16'h003B, 16'h003C, 16'h003F,
                  16'h0040, 16'h005F, 16'h0060, 16'h085F, 16'h0860};
        RST_B = 1'b0;
        repeat (4) @(posedge CLK);
        #1 RST_B = 1'b1;
        rd_chk(A_CTRL, 8'h00);
        rd_chk(A_DATA, dsea_pkg::DATA_RST);
        wr(A_ADHI, 8'hFF);
        rd_chk(A_ADHI, 8'h03);
        foreach (probe[i]) begin
            a  = probe[i];
            nv = (a >= A_CTRL && a <= A_ADHI);
            cpu.peek(a);
            `CHK(RF_SEL, a <= dsea_pkg::RF_LAST)
            `CHK(IO_SEL, a >= dsea_pkg::IO_BASE && a <= dsea_pkg::IO_LAST && !nv)
            `CHK(SRAM_SEL, a >= dsea_pkg::SRAM_BASE && a <= dsea_pkg::SRAM_LAST)
            if (IO_SEL === 1'b1) `CHK(IO_NUM, 6'(a - dsea_pkg::IO_BASE))
        end
        // SRAM edges, unmapped and register-file answers
        wr(16'h0060, 8'h3C);
        `CHK(cpu.lat, 2)
        wr(16'h085F, 8'hC3);
        rd_chk(16'h0060, 8'h3C);
        `CHK(cpu.lat, 2)
        rd_chk(16'h085F, 8'hC3);
        rd_chk(16'h0860, 8'h00);
        cpu.access(1'b0, 16'h0010, 8'h00);
        `CHK(cpu.got_done, 1'b0)
        // Write, with refused accesses while it runs
        nv_load(10'h3FF, 8'hA5);
        wr(A_CTRL, 8'h04);
        wr(A_CTRL, 8'h02);
        `CHK(cpu.halt_n, 2)
        cpu.access(1'b0, A_CTRL, 8'h00);
        `CHK(cpu.rdata[1], 1'b1)
        wr(A_ADLO, 8'h00);
        rd_chk(A_ADLO, 8'hFF);
        wr(A_CTRL, 8'h01);
        `CHK(cpu.halt_n, 0)
        wait_idle(polls);
        `CHK(polls > 3 && polls < 20, 1'b1)
        wr(A_CTRL, 8'h01);
        `CHK(cpu.halt_n, 4)
        rd_chk(A_DATA, 8'hA5);
        rd_chk(A_CTRL, 8'h00);
        nv_write(10'h000, 8'h11);
        nv_read(10'h3FF, 8'hA5);
        nv_read(10'h000, 8'h11);
        // Unarmed, same-write and late strobes must all be refused
        for (int k = 0; k < 3; k++) begin
            nv_load(10'h000, 8'h5A);
            if (k == 0) wr(A_CTRL, 8'h02);
            if (k == 1) wr(A_CTRL, 8'h06);
            if (k == 2) begin
                wr(A_CTRL, 8'h04);
                repeat (6) @(posedge CLK);
                wr(A_CTRL, 8'h02);
            end
            cpu.access(1'b0, A_CTRL, 8'h00);
            `CHK(cpu.rdata[1], 1'b0)
            nv_read(10'h000, 8'h11);
        end
        wrap_up();
    end
endmodule : dsea_top_tb
